/* hw/cms_pkg.sv */
/*
  Package for the clock, mute and pin status register bank.
  Assumes a byte-wide register port with page select supplied by the control port logic.
*/
package cms_pkg;
  // ****************************************
  // Register offsets and pages
  // ****************************************
  localparam logic [7:0] CMS_CLOCK_FAULT_STATUS_OFS = 8'h5F;
  localparam logic [7:0] CMS_ANALOG_MUTE_MONITOR_OFS = 8'h6C;
  localparam logic [7:0] CMS_PIN_LEVEL_STATUS_OFS = 8'h77;
  localparam logic [7:0] CMS_AUTO_MUTE_STATUS_OFS = 8'h78;
  localparam logic [7:0] CMS_OUTPUT_AMPLITUDE_SELECT_OFS = 8'h01;
  localparam logic [7:0] CMS_PAGE0 = 8'h00;
  localparam logic [7:0] CMS_PAGE1 = 8'h01;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CMS_LATCHED_HALT_BIT = 4;
  localparam int CMS_FRAME_BIT_ABSENT_BIT = 2;
  localparam int CMS_RESYNC_BIT = 1;
  localparam int CMS_CLOCK_ERROR_BIT = 0;
  localparam int CMS_LEFT_ANALOG_MUTE_BIT = 1;
  localparam int CMS_RIGHT_ANALOG_MUTE_BIT = 0;
  localparam int CMS_SERIAL_OUT_PIN_BIT = 5;
  localparam int CMS_MUTE_PIN_BIT = 4;
  localparam int CMS_LEFT_AUTO_MUTE_BIT = 4;
  localparam int CMS_RIGHT_AUTO_MUTE_BIT = 0;
  localparam int CMS_AMPLITUDE_TYPE_BIT = 0;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] CMS_RW_RESET = 8'h00;
  localparam logic CMS_AMPLITUDE_TYPE_RESET = 1'b0;
  // Reserved read/write bits that store what the host writes
  localparam logic [7:0] CMS_CLOCK_FAULT_RW_MASK = 8'hE8;
  localparam logic [7:0] CMS_ANALOG_MUTE_RW_MASK = 8'hFC;
  localparam logic [7:0] CMS_PIN_LEVEL_RW_MASK = 8'hC0;
  localparam logic [7:0] CMS_AUTO_MUTE_RW_MASK = 8'hEE;
  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic mclk_halt;
    logic frame_clock_missing;
    logic bit_clock_missing;
    logic resync_in_progress;
    logic clock_error;
  } cms_clock_flags_t;

  typedef struct packed {
    logic left_analog_unmuted;
    logic right_analog_unmuted;
    logic left_auto_muted;
    logic right_auto_muted;
  } cms_mute_flags_t;

  typedef struct packed {
    logic serial_data_output_pin;
    logic mute_pin;
  } cms_pin_levels_t;
endpackage

/* hw/cms_status_regs.sv */
/*
  Clock fault, mute monitor, pin level and amplitude select register bank.
  Assumes the control port supplies page and offset, decoded here, and gives one-cycle read and write strobes;
  read data is presented the cycle after the read strobe.
*/
`timescale 1ns/10ps
`default_nettype none
// What this block does
// (R01) Bit 4 of the clock fault register latches a master clock halt until read, then clears on that read.
// (R02) Bit 2 of the clock fault register is one only while both frame and bit clocks are held low.
// (R03) Bit 1 of the clock fault register is one while clock resynchronization runs.
// (R04) Bit 0 of the clock fault register latches a clock error until read, then clears on that read.
// (R05) Analog mute monitor bits 1 and 0 show left and right analog mute, zero meaning muted.
// (R06) Bit 5 of the pin level register shows the level of the serial data output pin.
// (R07) Bit 4 of the pin level register shows the level of the mute pin.
// (R08) The host ignores the low four bits of the pin level register, which may vary.
// (R09) Auto mute bits 4 and 0 show left and right auto mute, one meaning auto muted.
// (R10) Page one register 1 bit 0 selects the amplitude type, zero constant reference, one supply proportional, reset zero.
// (R11) With supply proportional mode and the PLL on, the host programs clock dividers by hand.
// (R12) Reserved read/write fields reset to zero.
// (R13) The latched halt and error flags clear only on a read of their register, never on a write.
module cms_status_regs (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_page,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire cms_pkg::cms_clock_flags_t clock_flags,
  input wire cms_pkg::cms_mute_flags_t mute_flags,
  input wire cms_pkg::cms_pin_levels_t pin_levels,
  output logic [7:0] reg_rdata,
  output logic amplitude_type_select
);
  // ****************************************
  // Register state
  // ****************************************
  logic latched_halt_flag_q, latched_halt_flag_d;
  logic latched_clock_error_q, latched_clock_error_d;
  logic [7:0] rsvd_5f_q, rsvd_5f_d;
  logic [7:0] rsvd_6c_q, rsvd_6c_d;
  logic [7:0] rsvd_77_q, rsvd_77_d;
  logic [7:0] rsvd_78_q, rsvd_78_d;
  logic [7:0] p1_r1_q, p1_r1_d;
  logic [7:0] rdata_q, rdata_d;
  logic amp_sel_q;
  logic frame_bit_clock_absent;
  logic sel_5f, sel_6c, sel_77, sel_78, sel_p1;

  function automatic logic hit(input logic [7:0] page, input logic [7:0] addr,
                               input logic [7:0] want_page, input logic [7:0] want_addr);
    hit = (page == want_page) && (addr == want_addr);
  endfunction

  // ****************************************
  // Address decode
  // ****************************************
  always_comb begin
    sel_5f = hit(reg_page, reg_addr, cms_pkg::CMS_PAGE0, cms_pkg::CMS_CLOCK_FAULT_STATUS_OFS);
    sel_6c = hit(reg_page, reg_addr, cms_pkg::CMS_PAGE0, cms_pkg::CMS_ANALOG_MUTE_MONITOR_OFS);
    sel_77 = hit(reg_page, reg_addr, cms_pkg::CMS_PAGE0, cms_pkg::CMS_PIN_LEVEL_STATUS_OFS);
    sel_78 = hit(reg_page, reg_addr, cms_pkg::CMS_PAGE0, cms_pkg::CMS_AUTO_MUTE_STATUS_OFS);
    sel_p1 = hit(reg_page, reg_addr, cms_pkg::CMS_PAGE1, cms_pkg::CMS_OUTPUT_AMPLITUDE_SELECT_OFS);
    frame_bit_clock_absent = clock_flags.frame_clock_missing && clock_flags.bit_clock_missing; // [R02]
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    latched_halt_flag_d = latched_halt_flag_q;
    latched_clock_error_d = latched_clock_error_q;
    // Read clears, but a new event in the same cycle survives
    if (reg_rd && sel_5f) begin
      latched_halt_flag_d = 1'b0; // [R01] [R13]
      latched_clock_error_d = 1'b0; // [R04] [R13]
    end
    if (clock_flags.mclk_halt) begin
      latched_halt_flag_d = 1'b1; // [R01]
    end
    if (clock_flags.clock_error) begin
      latched_clock_error_d = 1'b1; // [R04]
    end
    // Only reserved R/W fields and the page one register store; read-only bits are kept out by masks
    rsvd_5f_d = (reg_wr && sel_5f) ? (reg_wdata & cms_pkg::CMS_CLOCK_FAULT_RW_MASK) : rsvd_5f_q; // [R12]
    rsvd_6c_d = (reg_wr && sel_6c) ? (reg_wdata & cms_pkg::CMS_ANALOG_MUTE_RW_MASK) : rsvd_6c_q; // [R12]
    rsvd_77_d = (reg_wr && sel_77) ? (reg_wdata & cms_pkg::CMS_PIN_LEVEL_RW_MASK) : rsvd_77_q; // [R12]
    rsvd_78_d = (reg_wr && sel_78) ? (reg_wdata & cms_pkg::CMS_AUTO_MUTE_RW_MASK) : rsvd_78_q; // [R12]
    p1_r1_d = (reg_wr && sel_p1) ? reg_wdata : p1_r1_q; // [R10]
    rdata_d = 8'h00;
    if (reg_rd) begin
      if (sel_5f) begin
        rdata_d = rsvd_5f_q;
        rdata_d[cms_pkg::CMS_LATCHED_HALT_BIT] = latched_halt_flag_q; // [R01]
        rdata_d[cms_pkg::CMS_FRAME_BIT_ABSENT_BIT] = frame_bit_clock_absent; // [R02]
        rdata_d[cms_pkg::CMS_RESYNC_BIT] = clock_flags.resync_in_progress; // [R03]
        rdata_d[cms_pkg::CMS_CLOCK_ERROR_BIT] = latched_clock_error_q; // [R04]
      end else if (sel_6c) begin
        rdata_d = rsvd_6c_q;
        rdata_d[cms_pkg::CMS_LEFT_ANALOG_MUTE_BIT] = mute_flags.left_analog_unmuted; // [R05]
        rdata_d[cms_pkg::CMS_RIGHT_ANALOG_MUTE_BIT] = mute_flags.right_analog_unmuted; // [R05]
      end else if (sel_77) begin
        // Low nibble reads zero here; the host must not rely on it
        rdata_d = rsvd_77_q; // [R08]
        rdata_d[cms_pkg::CMS_SERIAL_OUT_PIN_BIT] = pin_levels.serial_data_output_pin; // [R06]
        rdata_d[cms_pkg::CMS_MUTE_PIN_BIT] = pin_levels.mute_pin; // [R07]
      end else if (sel_78) begin
        rdata_d = rsvd_78_q;
        rdata_d[cms_pkg::CMS_LEFT_AUTO_MUTE_BIT] = mute_flags.left_auto_muted; // [R09]
        rdata_d[cms_pkg::CMS_RIGHT_AUTO_MUTE_BIT] = mute_flags.right_auto_muted; // [R09]
      end else if (sel_p1) begin
        rdata_d = p1_r1_q; // [R10]
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      latched_halt_flag_q <= 1'b0;
      latched_clock_error_q <= 1'b0;
      rsvd_5f_q <= cms_pkg::CMS_RW_RESET; // [R12]
      rsvd_6c_q <= cms_pkg::CMS_RW_RESET;
      rsvd_77_q <= cms_pkg::CMS_RW_RESET;
      rsvd_78_q <= cms_pkg::CMS_RW_RESET;
      p1_r1_q <= cms_pkg::CMS_RW_RESET; // [R10]
      rdata_q <= 8'h00;
      amp_sel_q <= cms_pkg::CMS_AMPLITUDE_TYPE_RESET;
    end else begin
      latched_halt_flag_q <= latched_halt_flag_d;
      latched_clock_error_q <= latched_clock_error_d;
      rsvd_5f_q <= rsvd_5f_d;
      rsvd_6c_q <= rsvd_6c_d;
      rsvd_77_q <= rsvd_77_d;
      rsvd_78_q <= rsvd_78_d;
      p1_r1_q <= p1_r1_d;
      rdata_q <= rdata_d;
      amp_sel_q <= p1_r1_d[cms_pkg::CMS_AMPLITUDE_TYPE_BIT]; // [R10]
    end
  end

  assign reg_rdata = rdata_q;
  assign amplitude_type_select = amp_sel_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ****************************************
  // Clock fault register checks
  // ****************************************
  a_halt_latches: assert property (clock_flags.mclk_halt |=> latched_halt_flag_q) // [R01]
    else $error("halt event not latched");
  a_halt_read_clear: assert property (reg_rd && sel_5f && !clock_flags.mclk_halt |=> !latched_halt_flag_q) // [R01]
    else $error("halt flag not cleared by read");
  a_halt_read_shows: assert property (reg_rd && sel_5f |=> // [R01]
      reg_rdata[cms_pkg::CMS_LATCHED_HALT_BIT] == $past(latched_halt_flag_q))
    else $error("halt flag read mismatch");
  a_absent_read: assert property (reg_rd && sel_5f |=> // [R02]
      reg_rdata[cms_pkg::CMS_FRAME_BIT_ABSENT_BIT] ==
      ($past(clock_flags.frame_clock_missing) && $past(clock_flags.bit_clock_missing)))
    else $error("clock absent bit wrong");
  a_resync_read: assert property (reg_rd && sel_5f |=> // [R03]
      reg_rdata[cms_pkg::CMS_RESYNC_BIT] == $past(clock_flags.resync_in_progress))
    else $error("resync bit wrong");
  a_error_latches: assert property (clock_flags.clock_error |=> latched_clock_error_q) // [R04]
    else $error("clock error not latched");
  a_error_read_clear: assert property (reg_rd && sel_5f && !clock_flags.clock_error |=> // [R04]
      !latched_clock_error_q)
    else $error("error flag not cleared by read");
  a_error_read_shows: assert property (reg_rd && sel_5f |=> // [R04]
      reg_rdata[cms_pkg::CMS_CLOCK_ERROR_BIT] == $past(latched_clock_error_q))
    else $error("error flag read mismatch");
  a_write_keeps: assert property (reg_wr && !reg_rd && sel_5f |=> // [R13]
      latched_halt_flag_q == $past(latched_halt_flag_q || clock_flags.mclk_halt))
    else $error("write disturbed latched flag");
  a_error_write_keeps: assert property (reg_wr && !reg_rd && sel_5f |=> // [R13]
      latched_clock_error_q == $past(latched_clock_error_q || clock_flags.clock_error))
    else $error("write disturbed error flag");

  // ****************************************
  // Monitor and pin register checks
  // ****************************************
  a_mute_read: assert property (reg_rd && sel_6c |=> // [R05]
      reg_rdata[cms_pkg::CMS_LEFT_ANALOG_MUTE_BIT] == $past(mute_flags.left_analog_unmuted) &&
      reg_rdata[cms_pkg::CMS_RIGHT_ANALOG_MUTE_BIT] == $past(mute_flags.right_analog_unmuted))
    else $error("analog mute read wrong");
  a_pins_read: assert property (reg_rd && sel_77 |=> // [R06] [R07]
      reg_rdata[cms_pkg::CMS_SERIAL_OUT_PIN_BIT] == $past(pin_levels.serial_data_output_pin) &&
      reg_rdata[cms_pkg::CMS_MUTE_PIN_BIT] == $past(pin_levels.mute_pin))
    else $error("pin level read wrong");
  a_auto_read: assert property (reg_rd && sel_78 |=> // [R09]
      reg_rdata[cms_pkg::CMS_LEFT_AUTO_MUTE_BIT] == $past(mute_flags.left_auto_muted) &&
      reg_rdata[cms_pkg::CMS_RIGHT_AUTO_MUTE_BIT] == $past(mute_flags.right_auto_muted))
    else $error("auto mute read wrong");

  // ****************************************
  // Amplitude select checks
  // ****************************************
  a_amp_write: assert property (reg_wr && sel_p1 |=> // [R10]
      amplitude_type_select == $past(reg_wdata[cms_pkg::CMS_AMPLITUDE_TYPE_BIT]))
    else $error("amplitude select not updated");
  a_amp_hold: assert property (!(reg_wr && sel_p1) |=> $stable(amplitude_type_select)) // [R10]
    else $error("amplitude select changed without write");
  a_amp_readback: assert property (reg_rd && sel_p1 |=> // [R10]
      reg_rdata[cms_pkg::CMS_AMPLITUDE_TYPE_BIT] == $past(amplitude_type_select))
    else $error("amplitude select readback wrong");

  // ****************************************
  // Scenario covers
  // ****************************************
  c_halt_read: cover property (latched_halt_flag_q && reg_rd && sel_5f);
  c_error_set_on_read: cover property (clock_flags.clock_error && reg_rd && sel_5f);
  c_amp_set: cover property (reg_wr && sel_p1 && reg_wdata[0]);
  c_write_during_latch: cover property (latched_halt_flag_q && reg_wr && sel_5f);
  c_both_clocks_absent: cover property (reg_rd && sel_5f && frame_bit_clock_absent);
endmodule
`default_nettype wire

/* sim/cms_host_model.sv */
/*
  Host controller model for the status register bank's control port.
  Assumes one clock; strobes are driven on its falling edge and held for one rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module cms_host_model (
  input wire logic clk_sys,
  output logic [7:0] reg_page,
  output logic [7:0] reg_addr,
  output logic reg_rd,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_page = 8'h00;
    reg_addr = 8'h00;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic rd(input logic [7:0] pg, input logic [7:0] ad, output logic [7:0] d);
    @(negedge clk_sys);
    reg_page = pg;
    reg_addr = ad;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    d = reg_rdata;
    reg_rd = 1'b0;
  endtask
  // Divider setup for supply proportional mode lies outside this bank
  task automatic wr(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] v);
    @(negedge clk_sys);
    reg_page = pg;
    reg_addr = ad;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    // Released data must not look like the last value
    reg_wdata = ~v;
  endtask
endmodule
`default_nettype wire

/* sim/test_clock_mute_status_registers.sv */
/*
  Testbench for the clock, mute and pin status register bank.
  Assumes the host model drives the control port; status inputs come from here.
*/
`timescale 1ns/10ps
`default_nettype none
module test_clock_mute_status_registers;
  logic clk_sys;
  logic rst;
  logic [7:0] reg_page;
  logic [7:0] reg_addr;
  logic reg_rd;
  logic reg_wr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic amplitude_type_select;
  cms_pkg::cms_clock_flags_t clock_flags;
  cms_pkg::cms_mute_flags_t mute_flags;
  cms_pkg::cms_pin_levels_t pin_levels;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] d;
  cms_status_regs u_dut (.clk_sys(clk_sys), .rst(rst), .reg_page(reg_page), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .clock_flags(clock_flags),
    .mute_flags(mute_flags), .pin_levels(pin_levels), .reg_rdata(reg_rdata),
    .amplitude_type_select(amplitude_type_select));
  cms_host_model u_host (.clk_sys(clk_sys), .reg_page(reg_page), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t got 0x%0h expected 0x%0h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // ****************************************
  // Hang guard
  // ****************************************
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      stop_test();
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_values;
    u_host.rd(8'h00, 8'h77, d);
    chk(d, 8'h00);
    u_host.rd(8'h01, 8'h01, d);
    chk(d, 8'h00);
    chk({7'h00, amplitude_type_select}, 8'h00);
  endtask
  task automatic t_latch_clear;
    // Latch pulses, then a write that must not clear them
    @(negedge clk_sys);
    clock_flags = 5'h11;
    @(negedge clk_sys);
    clock_flags = 5'h00;
    u_host.wr(8'h00, 8'h5F, 8'hFF);
    u_host.rd(8'h00, 8'h5F, d);
    chk(d, 8'hF9);
    @(negedge clk_sys);
    chk(reg_rdata, 8'h00);
    u_host.rd(8'h00, 8'h5F, d);
    chk(d, 8'hE8);
    // Events present in the clearing read cycle must survive it
    clock_flags = 5'h11;
    u_host.rd(8'h00, 8'h5F, d);
    clock_flags = 5'h00;
    chk(d, 8'hF9);
    u_host.rd(8'h00, 8'h5F, d);
    chk(d, 8'hF9);
    u_host.rd(8'h00, 8'h5F, d);
    chk(d, 8'hE8);
    u_host.wr(8'h00, 8'h5F, 8'h00);
  endtask
  task automatic t_clock_bits;
    for (int i = 0; i < 8; i++) begin
      clock_flags = {1'b0, i[2:0], 1'b0};
      u_host.rd(8'h00, 8'h5F, d);
      chk(d, {5'h00, i[2] & i[1], i[0], 1'b0});
    end
    clock_flags = 5'h00;
  endtask
  task automatic t_mute_bits;
    for (int i = 0; i < 16; i++) begin
      mute_flags = i[3:0];
      u_host.rd(8'h00, 8'h6C, d);
      chk(d, {6'h00, i[3], i[2]});
      u_host.rd(8'h00, 8'h78, d);
      chk(d, {3'h0, i[1], 3'h0, i[0]});
    end
    mute_flags = 4'h0;
  endtask
  task automatic t_pin_bits;
    // Low nibble of the pin register is not judged
    for (int i = 0; i < 4; i++) begin
      pin_levels = i[1:0];
      u_host.rd(8'h00, 8'h77, d);
      chk(d & 8'hF0, {2'h0, i[1:0], 4'h0});
    end
    pin_levels = 2'h0;
  endtask
  task automatic t_amp_select;
    u_host.wr(8'h01, 8'h01, 8'h01);
    chk({7'h00, amplitude_type_select}, 8'h01);
    u_host.wr(8'h00, 8'h01, 8'hFF);
    u_host.rd(8'h00, 8'h01, d);
    chk(d, 8'h00);
    u_host.rd(8'h01, 8'h01, d);
    chk(d, 8'h01);
    u_host.wr(8'h01, 8'h01, 8'h00);
    chk({7'h00, amplitude_type_select}, 8'h00);
  endtask
  task automatic t_reserved_rw;
    // Read-only bits must ignore the ones written here
    u_host.wr(8'h00, 8'h6C, 8'hFF);
    u_host.wr(8'h00, 8'h77, 8'hFF);
    u_host.wr(8'h00, 8'h78, 8'hFF);
    u_host.rd(8'h00, 8'h6C, d);
    chk(d, 8'hFC);
    u_host.rd(8'h00, 8'h77, d);
    chk(d & 8'hF0, 8'hC0);
    u_host.rd(8'h00, 8'h78, d);
    chk(d, 8'hEE);
  endtask
  task automatic t_mid_reset;
    u_host.wr(8'h01, 8'h01, 8'hFF);
    @(negedge clk_sys);
    clock_flags = 5'h11;
    @(negedge clk_sys);
    clock_flags = 5'h00;
    rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    chk({7'h00, amplitude_type_select}, 8'h00);
    u_host.rd(8'h00, 8'h5F, d);
    chk(d, 8'h00);
    u_host.rd(8'h00, 8'h6C, d);
    chk(d, 8'h00);
    u_host.rd(8'h00, 8'h77, d);
    chk(d & 8'hF0, 8'h00);
    u_host.rd(8'h00, 8'h78, d);
    chk(d, 8'h00);
    u_host.rd(8'h01, 8'h01, d);
    chk(d, 8'h00);
  endtask
  initial begin
    rst = 1'b1;
    clock_flags = 5'h00;
    mute_flags = 4'h0;
    pin_levels = 2'h0;
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    t_reset_values();
    t_latch_clear();
    t_clock_bits();
    t_mute_bits();
    t_pin_bits();
    t_amp_select();
    t_reserved_rw();
    t_mid_reset();
    stop_test();
  end
endmodule
`default_nettype wire
